// *** rtl/ppsr_map.vh ***
// Register offsets, field positions, reset values and timing for ppsr
`ifndef PPSR_MAP_VH
`define PPSR_MAP_VH

// Register indices; byte address is four times the index
`define PPSR_IDX_NODE_ID        4'h0
`define PPSR_IDX_HOLDOFF_GAP    4'h1
`define PPSR_IDX_CORE_IDENT     4'h2
`define PPSR_IDX_LINE_STATUS    4'h3
`define PPSR_IDX_RSVD_FOUR      4'h4
`define PPSR_IDX_RSVD_FIVE      4'h5
`define PPSR_IDX_IRQ_FLAGS      4'h6
`define PPSR_IDX_RSVD_SEVEN     4'h7
`define PPSR_IDX_RSVD_EIGHT     4'h8
`define PPSR_IDX_LAST           4'h8

// Line state codes
`define PPSR_LS_HIGHZ           2'h3
`define PPSR_LS_ONE             2'h1
`define PPSR_LS_ZERO            2'h2
`define PPSR_LS_INVALID         2'h0

// Data bit positions within each register byte, and field reset values
`define PPSR_PWR_OK_BIT_R0      0
`define PPSR_CON_BIT            2
`define PPSR_CHILD_BIT          3
`define PPSR_RST_HERE_BIT       4
`define PPSR_PWR_OK_BIT_R6      5
`define PPSR_PWR_IRQ_BIT        6
`define PPSR_LOOP_IRQ_BIT       7
`define PPSR_GAP_RESET          6'h3F
`define PPSR_NODE_ADDR_RESET    6'h09

// Debounce cycle counts at 20 MHz: 335 ms and 1.3 ms
`define PPSR_CONNECT_CYC        24'h66_3BE0
`define PPSR_DISCONNECT_CYC     24'h00_6590

`endif

// *** rtl/ppsr_regs.v ***
// Port status register bank with Avalon-MM slave and debounce
`timescale 1ns/1ps
`include "ppsr_map.vh"

module ppsr_regs
(
	clk,
	reset,
	avs_address,
	avs_read,
	avs_write,
	avs_writedata,
	avs_readdata,
	avs_waitrequest,
	pair_a_code,
	pair_b_code,
	line_busy,
	tree_id_done,
	tree_child,
	cable_present,
	bus_reset_active,
	cable_power_pin,
	bus_reset_req
);
	input  wire        clk;
	input  wire        reset;
	input  wire [5:0]  avs_address;
	input  wire        avs_read;
	input  wire        avs_write;
	input  wire [31:0] avs_writedata;
	output reg  [31:0] avs_readdata;
	output reg         avs_waitrequest;
	input  wire [1:0]  pair_a_code;
	input  wire [1:0]  pair_b_code;
	input  wire        line_busy;
	input  wire        tree_id_done;
	input  wire        tree_child;
	input  wire        cable_present;
	input  wire        bus_reset_active;
	input  wire        cable_power_pin;
	output reg         bus_reset_req;

	// Debounce limits
	localparam [23:0] CONN_CYC = `PPSR_CONNECT_CYC;
	localparam [23:0] DISC_CYC = `PPSR_DISCONNECT_CYC;

	// Register state
	reg  [1:0]  pair_a_line_state_reg;
	reg  [1:0]  pair_b_line_state_reg;
	reg         child_flag_reg;
	reg         child_valid_reg;
	reg         connected_reg;
	reg         cable_power_ok_reg;
	reg         cable_power_irq_reg;
	reg         loop_timeout_irq_reg;
	reg         root_holdoff_reg;
	reg         force_bus_reset_reg;
	reg  [5:0]  gap_count_reg;
	reg         stable_reg;
	reg  [23:0] debounce_reg;
	reg         done_reg;

	// Next values
	reg  [1:0]  pair_a_line_state_next;
	reg  [1:0]  pair_b_line_state_next;
	reg         child_flag_next;
	reg         child_valid_next;
	reg         connected_next;
	reg         cable_power_irq_next;
	reg         root_holdoff_next;
	reg         force_bus_reset_next;
	reg  [5:0]  gap_count_next;
	reg         stable_next;
	reg  [23:0] debounce_next;
	reg         bus_reset_req_next;
	reg         done_next;
	reg         waitrequest_next;
	reg  [31:0] readdata_next;
	reg  [7:0]  read_byte;

	// Bus and debounce decode
	wire [3:0]  index;
	wire        word_ok;
	wire        access;
	wire        wr_hit;
	wire        wr_gap;
	wire        pwr_irq_clear;
	wire        differs;
	wire        conn_due;
	wire        disc_due;

	// Decoded line state, invalid during packets
	function [1:0] line_code;
		input [1:0] code;
		input       busy;
		begin
			if (busy)
				line_code = `PPSR_LS_INVALID;
			else
				line_code = code;
		end
	endfunction

	// Aligned access to one register index
	function reg_hit;
		input [3:0] idx;
		input [3:0] want;
		input       aligned;
		begin
			reg_hit = aligned & (idx == want);
		end
	endfunction

	// Debounce limit reached
	function debounce_due;
		input [23:0] count;
		input [23:0] limit;
		begin
			debounce_due = (count >= limit - 24'h00_0001);
		end
	endfunction

	// Bus decode
	assign index   = avs_address[5:2];
	assign word_ok = (avs_address[1:0] == 2'b00);
	assign access  = (avs_read | avs_write) & ~done_reg;
	// Writes land at the edge that sees waitrequest low
	assign wr_hit  = avs_write & done_reg & word_ok;
	assign wr_gap  = wr_hit
		& reg_hit(index, `PPSR_IDX_HOLDOFF_GAP, word_ok);
	assign pwr_irq_clear = wr_hit
		& reg_hit(index, `PPSR_IDX_IRQ_FLAGS, word_ok)
		& ~avs_writedata[`PPSR_PWR_IRQ_BIT];

	// Debounce decode
	assign differs  = (cable_present != stable_reg);
	assign conn_due = differs & cable_present
		& debounce_due(debounce_reg, CONN_CYC);
	assign disc_due = differs & ~cable_present
		& debounce_due(debounce_reg, DISC_CYC);

	// Read mux
	always @*
	begin
		read_byte = 8'h00;
		if (word_ok)
		begin
			case (index)
				`PPSR_IDX_NODE_ID:
				begin
					read_byte = {`PPSR_NODE_ADDR_RESET, 1'b0,
						cable_power_ok_reg};
				end
				`PPSR_IDX_HOLDOFF_GAP:
				begin
					read_byte = {root_holdoff_reg, force_bus_reset_reg,
						gap_count_reg};
				end
				`PPSR_IDX_LINE_STATUS:
				begin
					read_byte = {pair_a_line_state_reg,
						pair_b_line_state_reg,
						child_flag_reg & child_valid_reg,
						connected_reg, 2'b00};
				end
				`PPSR_IDX_IRQ_FLAGS:
				begin
					read_byte = {loop_timeout_irq_reg,
						cable_power_irq_reg,
						cable_power_ok_reg, 1'b0,
						4'h0};
				end
				default:
				begin
					read_byte = 8'h00;
				end
			endcase
		end
	end

	// Bus response next values
	always @*
	begin
		done_next        = access;
		waitrequest_next = ~access;
		readdata_next    = avs_readdata;
		if (avs_read & ~done_reg)
			readdata_next = {24'h00_0000, read_byte};
	end

	// Bus slave: one wait cycle, answer on the second edge
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
			done_reg        <= 1'b0;
		end
		else
		begin
			avs_waitrequest <= waitrequest_next;
			avs_readdata    <= readdata_next;
			done_reg        <= done_next;
		end
	end

	// Line state next values
	always @*
	begin
		pair_a_line_state_next = line_code(pair_a_code, line_busy);
		pair_b_line_state_next = line_code(pair_b_code, line_busy);
	end

	// Line state registers
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pair_a_line_state_reg <= `PPSR_LS_INVALID;
			pair_b_line_state_reg <= `PPSR_LS_INVALID;
		end
		else
		begin
			pair_a_line_state_reg <= pair_a_line_state_next;
			pair_b_line_state_reg <= pair_b_line_state_next;
		end
	end

	// Child and connection next values
	always @*
	begin
		child_flag_next  = child_flag_reg;
		child_valid_next = child_valid_reg;
		connected_next   = connected_reg;
		if (bus_reset_active)
		begin
			child_valid_next = 1'b0;
			connected_next   = cable_present;
		end
		else if (tree_id_done)
		begin
			child_valid_next = 1'b1;
			child_flag_next  = tree_child;
		end
	end

	// Child and connection registers
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			child_flag_reg  <= 1'b0;
			child_valid_reg <= 1'b0;
			connected_reg   <= 1'b1;
		end
		else
		begin
			child_flag_reg  <= child_flag_next;
			child_valid_reg <= child_valid_next;
			connected_reg   <= connected_next;
		end
	end

	// Cable power interrupt next value; set wins over clear
	always @*
	begin
		cable_power_irq_next = cable_power_irq_reg;
		if (~cable_power_pin)
			cable_power_irq_next = 1'b1;
		else if (pwr_irq_clear)
			cable_power_irq_next = 1'b0;
	end

	// Cable power and interrupt registers
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cable_power_ok_reg   <= 1'b0;
			cable_power_irq_reg  <= 1'b0;
			loop_timeout_irq_reg <= 1'b0;
		end
		else
		begin
			cable_power_ok_reg   <= cable_power_pin;
			cable_power_irq_reg  <= cable_power_irq_next;
			loop_timeout_irq_reg <= 1'b0;
		end
	end

	// Hold-off, forced reset and gap next values
	always @*
	begin
		root_holdoff_next    = root_holdoff_reg;
		force_bus_reset_next = force_bus_reset_reg;
		gap_count_next       = gap_count_reg;
		if (wr_gap)
		begin
			root_holdoff_next    = avs_writedata[7];
			force_bus_reset_next = avs_writedata[6];
			gap_count_next       = avs_writedata[5:0];
		end
		if (bus_reset_active)
			force_bus_reset_next = 1'b0;
	end

	// Hold-off, forced reset and gap registers
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			root_holdoff_reg    <= 1'b0;
			force_bus_reset_reg <= 1'b0;
			gap_count_reg       <= `PPSR_GAP_RESET;
		end
		else
		begin
			root_holdoff_reg    <= root_holdoff_next;
			force_bus_reset_reg <= force_bus_reset_next;
			gap_count_reg       <= gap_count_next;
		end
	end

	// Connection debounce next values
	always @*
	begin
		stable_next        = stable_reg;
		debounce_next      = 24'h00_0000;
		bus_reset_req_next = force_bus_reset_reg;
		if (conn_due)
		begin
			stable_next        = 1'b1;
			bus_reset_req_next = 1'b1;
		end
		else if (disc_due)
		begin
			stable_next        = 1'b0;
			bus_reset_req_next = 1'b1;
		end
		else if (differs)
			debounce_next = debounce_reg + 24'h00_0001;
	end

	// Connection debounce registers
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			stable_reg    <= 1'b1;
			debounce_reg  <= 24'h00_0000;
			bus_reset_req <= 1'b0;
		end
		else
		begin
			stable_reg    <= stable_next;
			debounce_reg  <= debounce_next;
			bus_reset_req <= bus_reset_req_next;
		end
	end

endmodule // ppsr_regs

// *** tb/ppsr_chk.sv ***
// Port checker for the port status register bank
`timescale 1ns/1ps
module ppsr_chk
(
	input wire        clk,
	input wire        reset,
	input wire [5:0]  avs_address,
	input wire        avs_read,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	input wire [1:0]  pair_a_code,
	input wire [1:0]  pair_b_code,
	input wire        line_busy,
	input wire        cable_power_pin
);
	reg  [1:0] up_reg;
	wire [7:0] rd = avs_readdata[7:0];
	wire [3:0] ix = avs_address[5:2];
	// Settle time after reset release
	always @(posedge clk or posedge reset)
		if (reset)
			up_reg <= 2'h0;
		else if (up_reg != 2'h3)
			up_reg <= up_reg + 2'h1;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_ack; up_reg == 2'h3 && avs_read && !avs_waitrequest; endsequence
	sequence s_rd3; s_ack ##0 avs_address == 6'h0C; endsequence
	sequence s_rd6; s_ack ##0 avs_address == 6'h18; endsequence
	sequence s_calm;
		(!line_busy && $stable(pair_a_code) && $stable(pair_b_code)) [*3];
	endsequence
	sequence s_pw; $stable(cable_power_pin) [*3]; endsequence
	property p_a_code; s_calm ##0 s_rd3 |-> rd[7:6] == pair_a_code; endproperty
	property p_b_code; s_calm ##0 s_rd3 |-> rd[5:4] == pair_b_code; endproperty
	property p_busy; line_busy [*3] ##0 s_rd3 |-> rd[7:4] == 4'h0; endproperty
	property p_rsvd_loc;
		s_ack ##0 (ix == 4'h4 || ix == 4'h5 || ix == 4'h7 || ix == 4'h8)
			|-> rd == 8'h00;
	endproperty
	property p_rsvd_bits; s_rd3 |-> rd[1:0] == 2'h0; endproperty
	property p_loop; s_rd6 |-> rd[7] == 1'b0 && rd[3:0] == 4'h0; endproperty
	property p_pwr; s_pw ##0 s_rd6 |-> rd[5] == cable_power_pin; endproperty
	property p_pwr_irq;
		(!cable_power_pin) [*3] ##0 s_rd6 |-> rd[6];
	endproperty
	a_a_code: assert property (p_a_code) else $error("pair A code");
	a_b_code: assert property (p_b_code) else $error("pair B code");
	a_busy: assert property (p_busy) else $error("busy code");
	a_rsvd_loc: assert property (p_rsvd_loc) else $error("rsvd loc");
	a_rsvd_bits: assert property (p_rsvd_bits) else $error("rsvd");
	a_loop: assert property (p_loop) else $error("loop flag");
	a_pwr: assert property (p_pwr) else $error("power bit");
	a_pwr_irq: assert property (p_pwr_irq) else $error("power irq");
endmodule // ppsr_chk

bind ppsr_regs ppsr_chk u_chk
(
	.clk             (clk),
	.reset           (reset),
	.avs_address     (avs_address),
	.avs_read        (avs_read),
	.avs_readdata    (avs_readdata),
	.avs_waitrequest (avs_waitrequest),
	.pair_a_code     (pair_a_code),
	.pair_b_code     (pair_b_code),
	.line_busy       (line_busy),
	.cable_power_pin (cable_power_pin)
);

// *** tb/ppsr_link.sv ***
// Link side model: Avalon-MM master for the register bank
`timescale 1ns/1ps
module ppsr_link
(
	input  wire        clk,
	output reg  [5:0]  avs_address,
	output reg         avs_read,
	output reg         avs_write,
	output reg  [31:0] avs_writedata,
	input  wire [31:0] avs_readdata,
	input  wire        avs_waitrequest
);
	reg hung;
	initial
	begin
		{avs_address, avs_read, avs_write, avs_writedata} = 40'h00_0000_0000;
		hung = 1'b0;
	end
	// One bus cycle, held until waitrequest is sampled low
	task xfer;
		input        wr;
		input  [5:0] adr;
		input  [7:0] wd;
		output [7:0] q;
		integer      n;
		begin
			n = 0;
			avs_address   <= adr;
			avs_writedata <= {24'h00_0000, wd};
			avs_read      <= !wr;
			avs_write     <= wr;
			@(posedge clk);
			while (avs_waitrequest && n < 100)
			begin
				@(posedge clk);
				n = n + 1;
			end
			q = avs_readdata[7:0];
			hung = hung | (n == 100);
			avs_read  <= 1'b0;
			avs_write <= 1'b0;
			@(posedge clk);
		end
	endtask
endmodule // ppsr_link

// *** tb/ppsr_regs_tb_top.sv ***
// Self-checking bench for the port status register bank
`timescale 1ns/1ps
module ppsr_regs_tb_top;
	reg         clk, reset, line_busy, tree_id_done, tree_child;
	reg         cable_present, bus_reset_active, cable_power_pin;
	reg  [1:0]  pair_a_code, pair_b_code;
	wire [5:0]  avs_address;
	wire        avs_read, avs_write, avs_waitrequest, bus_reset_req;
	wire [31:0] avs_writedata, avs_readdata;
	integer     n_mismatch, checks_done, i;
	reg  [7:0]  q;
	ppsr_regs dut
	(
		.clk              (clk),
		.reset            (reset),
		.avs_address      (avs_address),
		.avs_read         (avs_read),
		.avs_write        (avs_write),
		.avs_writedata    (avs_writedata),
		.avs_readdata     (avs_readdata),
		.avs_waitrequest  (avs_waitrequest),
		.pair_a_code      (pair_a_code),
		.pair_b_code      (pair_b_code),
		.line_busy        (line_busy),
		.tree_id_done     (tree_id_done),
		.tree_child       (tree_child),
		.cable_present    (cable_present),
		.bus_reset_active (bus_reset_active),
		.cable_power_pin  (cable_power_pin),
		.bus_reset_req    (bus_reset_req)
	);
	ppsr_link link
	(
		.clk             (clk),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest)
	);
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task conclude;
		begin
			if (n_mismatch == 0 && checks_done > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task cmp8;
		input [7:0] got, exp;
		begin
			checks_done = checks_done + 1;
			if (got !== exp)
			begin
				n_mismatch = n_mismatch + 1;
				$display("[ERR] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task acc;
		input w; input [5:0] a; input [7:0] d;
		begin
			link.xfer(w, a, d, q);
			if (link.hung)
			begin
				n_mismatch = n_mismatch + 1;
				conclude;
			end
		end
	endtask
	task rd;
		input [5:0] a; input [7:0] e;
		begin
			acc(1'b0, a, 8'h00);
			cmp8(q, e);
		end
	endtask
	initial
	begin
		n_mismatch = 0; checks_done = 0; reset = 1'b1;
		{line_busy, tree_id_done, tree_child, bus_reset_active} = 4'h0;
		{cable_present, cable_power_pin, pair_a_code, pair_b_code} = 6'h30;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rd(6'h0C, 8'h04);
		for (i = 0; i < 4; i = i + 1)
		begin
			pair_a_code <= i[1:0];
			pair_b_code <= ~i[1:0];
			@(posedge clk);
			rd(6'h0C, {i[1:0], ~i[1:0], 4'h4});
		end
		line_busy <= 1'b1;
		repeat (2) @(posedge clk);
		rd(6'h0C, 8'h04);
		line_busy <= 1'b0;
		tree_child <= 1'b1;
		tree_id_done <= 1'b1;
		@(posedge clk);
		tree_id_done <= 1'b0;
		rd(6'h0C, 8'hCC);
		cable_power_pin <= 1'b0;
		@(posedge clk);
		rd(6'h18, 8'h40);
		acc(1'b0, 6'h00, 8'h00);
		cmp8({7'h00, q[0]}, 8'h00);
		acc(1'b1, 6'h18, 8'h00);
		rd(6'h18, 8'h40);
		cable_power_pin <= 1'b1;
		@(posedge clk);
		acc(1'b1, 6'h18, 8'h8F);
		rd(6'h18, 8'h20);
		acc(1'b0, 6'h00, 8'h00);
		cmp8({7'h00, q[0]}, 8'h01);
		acc(1'b1, 6'h10, 8'hFF);
		for (i = 4; i < 9; i = i + 1)
			if (i != 6)
				rd({i[3:0], 2'b00}, 8'h00);
		rd(6'h0D, 8'h00);
		cable_present <= 1'b0;
		i = 0;
		while (!bus_reset_req && i < 30000)
		begin
			@(posedge clk);
			i = i + 1;
		end
		cmp8({7'h00, i > 25990 && i < 26010}, 8'h01);
		bus_reset_active <= 1'b1;
		repeat (4) @(posedge clk);
		bus_reset_active <= 1'b0;
		rd(6'h0C, 8'hC0);
		cable_present <= 1'b1;
		i = 0;
		while (!bus_reset_req && i < 3000)
		begin
			@(posedge clk);
			i = i + 1;
		end
		cmp8({7'h00, bus_reset_req}, 8'h00);
		conclude;
	end
endmodule // ppsr_regs_tb_top
